// ==== shared/eawc_pkg.sv ====
// Purpose: constants for the electrical angle timer and waveform calculator
// Assumes: APB register map, 32-bit data, one register per aligned word
// Notes: register offsets are byte addresses
package eawc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
    localparam logic [7:0] OFS_CALC_CTRL = 8'h04;
    localparam logic [7:0] OFS_PERIOD = 8'h08;
    localparam logic [7:0] OFS_ANGLE = 8'h0C;
    localparam logic [7:0] OFS_CAPTURE = 8'h10;
    localparam logic [7:0] OFS_AMPLITUDE = 8'h14;
    localparam logic [7:0] OFS_PWM_CYCLE = 8'h18;
    localparam logic [7:0] OFS_TABLE_DATA = 8'h1C;
    localparam logic [7:0] OFS_CMP_U = 8'h20;
    localparam logic [7:0] OFS_CMP_V = 8'h24;
    localparam logic [7:0] OFS_CMP_W = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    // timer control field positions
    localparam int BIT_TIMER_EN = 0;
    localparam int BIT_CALC_EN = 1;
    localparam int BIT_AUTOLOAD = 2;
    localparam int BIT_MOD_SEL = 3;
    localparam int BIT_CLK_SEL_LO = 4;
    localparam int BIT_PHASE_ORDER = 6;
    localparam int BIT_COUNT_DIR = 7;
    // calc control field positions
    localparam int BIT_IRQ_SEL = 0;
    localparam int BIT_SYNC_EN = 1;
    localparam int BIT_BUSY = 2;
    localparam int BIT_SW_START = 3;
    // angle range and phase offsets in counts
    localparam logic [8:0] ANGLE_MAX = 9'h17F;
    localparam logic [8:0] ANGLE_HALF = 9'h0C0;
    localparam logic [8:0] ANGLE_120 = 9'h080;
    localparam logic [8:0] ANGLE_240 = 9'h100;
    // least step period and trim group size
    localparam logic [11:0] PERIOD_MIN = 12'h010;
    localparam logic [4:0] TRIM_GROUP = 5'h10;
    // calculation time: 7 us at 20 MHz, scaled to our clock
    localparam int CALC_TIME_NS = 7000;
    localparam int SYS_CLK_MHZ = 200;
    localparam int CALC_CYCLES = (CALC_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_PERIOD = 16'h0010;
endpackage

// ==== verilog/eawc_top.sv ====
// Purpose: electrical angle timer with sine-table waveform calculator
// Assumes: APB slave, single clock, position detect on the POS_DETECT pin, angle write via bus
// Notes: calculation latency fixed at CALC_LEN clocks, CALC_CYCLES by default
//
// Summary of operation
// - angle counts 0..383 then wraps to 0
// - step at period end advances angle, may interrupt
// - n of 16 steps use period m+1, spread
// - period below 010H treated as 010H
// - angle readable and writable while running
// - position detection latches angle into capture
// - table entry times amplitude; 2-phase output
// - 3-phase: half period plus/minus half product
// - three results U, V+120, W+240 in sequence
// - phase order bit picks V/W offset direction
// - sync mode starts on step and angle write
// - software start restarts; busy flag readable
// - calculation lasts 35 machine cycles, 7 us
// - too-short step keeps previous results
// - autoload writes compares; software writes blocked
// - compare reads return results while enabled
// - irq select: step end or calc end
// - direction bit counts angle up or down
// - clock select changes without stopping timer
// - enable starts; disable stops, clears count
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
module eawc_top
    import eawc_pkg::*;
#(
    parameter int TABLE_WIDTH = 8,
    parameter int CALC_LEN = CALC_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic POS_DETECT,
    output logic ANGLE_IRQ,
    output logic [15:0] DUTY_DATA,
    output logic [1:0] DUTY_PHASE,
    output logic DUTY_VALID,
    output logic [15:0] CMP_U,
    output logic [15:0] CMP_V,
    output logic [15:0] CMP_W
);
    typedef enum logic [1:0] {CALC_IDLE, CALC_RUN, CALC_OUT} eawc_calc_type;

    logic [7:0] timer_ctrl_reg;
    logic [1:0] calc_ctrl_reg;
    logic [15:0] period_reg;
    logic [8:0] angle_counter_reg;
    logic [8:0] angle_capture_reg;
    logic [15:0] amp_reg;
    logic [15:0] pwm_cycle_reg;
    logic [TABLE_WIDTH-1:0] sine_table [0:383];
    logic [15:0] res_reg [0:2];
    logic [15:0] cmp_reg [0:2];
    logic [11:0] step_cnt_reg;
    logic [3:0] trim_phase_reg;
    logic [2:0] prescale_reg;
    logic [15:0] calc_cnt_reg;
    logic [1:0] out_idx_reg;
    eawc_calc_type calc_state_reg;
    logic pos_meta_reg;
    logic pos_sync_reg;
    logic pos_last_reg;

    logic wr_en;
    logic rd_en;
    logic step_done;
    logic tick;
    logic angle_wr;
    logic sw_start;
    logic sync_start;
    logic calc_start;
    logic calc_end;
    logic [11:0] period_eff;
    logic [11:0] step_target;
    logic lengthen;
    logic [8:0] ang_v;
    logic [8:0] ang_w;
    logic [4:0] trim_n;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    assign angle_wr = wr_en && PADDR == OFS_ANGLE;
    assign sw_start = wr_en && PADDR == OFS_CALC_CTRL && PWDATA[BIT_SW_START];

    // control register writes
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timer_ctrl_reg <= RST_CTRL;
            calc_ctrl_reg <= 2'h0;
            period_reg <= RST_PERIOD;
            amp_reg <= 16'h0000;
            pwm_cycle_reg <= 16'h0000;
        end else if (wr_en) begin
            unique case (PADDR)
                OFS_TIMER_CTRL: timer_ctrl_reg <= PWDATA[7:0];
                OFS_CALC_CTRL: calc_ctrl_reg <= PWDATA[1:0];
                OFS_PERIOD: period_reg <= PWDATA[15:0];
                OFS_AMPLITUDE: amp_reg <= PWDATA[15:0];
                OFS_PWM_CYCLE: pwm_cycle_reg <= PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // sine table fill, addressed by the angle counter
    always_ff @(posedge SYS_CLK) begin
        if (wr_en && PADDR == OFS_TABLE_DATA && !timer_ctrl_reg[BIT_CALC_EN]) begin
            sine_table[angle_counter_reg] <= PWDATA[TABLE_WIDTH-1:0];
        end
    end

    // read mux, registered in the setup cycle
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (PADDR)
                OFS_TIMER_CTRL: PRDATA <= {24'h0, timer_ctrl_reg};
                OFS_CALC_CTRL: PRDATA <= {29'h0, calc_state_reg != CALC_IDLE,
                    calc_ctrl_reg};
                OFS_PERIOD: PRDATA <= {16'h0, period_reg};
                OFS_ANGLE: PRDATA <= {23'h0, angle_counter_reg};
                OFS_CAPTURE: PRDATA <= {23'h0, angle_capture_reg};
                OFS_AMPLITUDE: PRDATA <= {16'h0, amp_reg};
                OFS_PWM_CYCLE: PRDATA <= {16'h0, pwm_cycle_reg};
                OFS_CMP_U: PRDATA <= {16'h0, timer_ctrl_reg[BIT_CALC_EN] ?
                    res_reg[0] : cmp_reg[0]};
                OFS_CMP_V: PRDATA <= {16'h0, timer_ctrl_reg[BIT_CALC_EN] ?
                    res_reg[1] : cmp_reg[1]};
                OFS_CMP_W: PRDATA <= {16'h0, timer_ctrl_reg[BIT_CALC_EN] ?
                    res_reg[2] : cmp_reg[2]};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // zero wait states, unmapped addresses flag an error
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && (PADDR > OFS_STATUS || PADDR[1:0] != 2'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timer clock prescale: select 0..3 gives divide by 1,2,4,8
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prescale_reg <= 3'h0;
        end else begin
            prescale_reg <= prescale_reg + 3'h1;
        end
    end

    // tick chosen live from the free counter, so a change never stalls
    always_comb begin
        unique case (timer_ctrl_reg[BIT_CLK_SEL_LO +: 2])
            2'h0: tick = 1'b1;
            2'h1: tick = prescale_reg[0];
            2'h2: tick = prescale_reg[1:0] == 2'h3;
            default: tick = prescale_reg == 3'h7;
        endcase
    end

    // period clamp and fractional trim
    assign period_eff = period_reg[11:0] < PERIOD_MIN ? PERIOD_MIN : period_reg[11:0];
    assign trim_n = {1'b0, period_reg[15:12]};
    // bresenham style spread of n lengthened steps over 16
    assign lengthen = (({1'b0, trim_phase_reg} * trim_n) % TRIM_GROUP) + trim_n
        >= TRIM_GROUP;
    assign step_target = period_eff + {11'h0, lengthen};
    assign step_done = timer_ctrl_reg[BIT_TIMER_EN] && tick
        && step_cnt_reg + 12'h1 >= step_target;

    // step counter
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            step_cnt_reg <= 12'h000;
            trim_phase_reg <= 4'h0;
        end else if (!timer_ctrl_reg[BIT_TIMER_EN]) begin
            step_cnt_reg <= 12'h000;
            trim_phase_reg <= 4'h0;
        end else if (step_done) begin
            step_cnt_reg <= 12'h000;
            trim_phase_reg <= trim_phase_reg + 4'h1;
        end else if (tick) begin
            step_cnt_reg <= step_cnt_reg + 12'h1;
        end
    end

    // angle counter: bus write wins over a step
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            angle_counter_reg <= 9'h000;
        end else if (angle_wr) begin
            angle_counter_reg <= PWDATA[8:0] > ANGLE_MAX ? ANGLE_MAX : PWDATA[8:0];
        end else if (step_done) begin
            if (timer_ctrl_reg[BIT_COUNT_DIR]) begin
                angle_counter_reg <= angle_counter_reg == 9'h000 ? ANGLE_MAX
                    : angle_counter_reg - 9'h001;
            end else begin
                angle_counter_reg <= angle_counter_reg == ANGLE_MAX ? 9'h000
                    : angle_counter_reg + 9'h001;
            end
        end
    end

    // position detect sync and capture on rising edge
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pos_meta_reg <= 1'b0;
            pos_sync_reg <= 1'b0;
            pos_last_reg <= 1'b0;
            angle_capture_reg <= 9'h000;
        end else begin
            pos_meta_reg <= POS_DETECT;
            pos_sync_reg <= pos_meta_reg;
            pos_last_reg <= pos_sync_reg;
            if (pos_sync_reg && !pos_last_reg) begin
                angle_capture_reg <= angle_counter_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calculation start sources
    assign sync_start = timer_ctrl_reg[BIT_CALC_EN] && calc_ctrl_reg[BIT_SYNC_EN]
        && (step_done || angle_wr);
    assign calc_start = sw_start || (sync_start && calc_state_reg == CALC_IDLE);
    assign calc_end = calc_state_reg == CALC_OUT && out_idx_reg == 2'h2;

    // phase angles, order set by the phase order bit
    function automatic logic [8:0] eawc_add_angle(input logic [8:0] a, input logic [8:0] d);
        logic [9:0] s;
        s = {1'b0, a} + {1'b0, d};
        eawc_add_angle = s > {1'b0, ANGLE_MAX} ? 9'(s - 10'h180) : s[8:0];
    endfunction
    assign ang_v = eawc_add_angle(angle_counter_reg,
        timer_ctrl_reg[BIT_PHASE_ORDER] ? ANGLE_240 : ANGLE_120);
    assign ang_w = eawc_add_angle(angle_counter_reg,
        timer_ctrl_reg[BIT_PHASE_ORDER] ? ANGLE_120 : ANGLE_240);

    // one phase result from table, amplitude and modulation mode
    function automatic logic [15:0] eawc_wave(input logic [8:0] a,
        input logic [TABLE_WIDTH-1:0] t);
        logic [31:0] prod;
        prod = 32'(t) * 32'(amp_reg);
        if (!timer_ctrl_reg[BIT_MOD_SEL]) begin
            eawc_wave = prod[15:0];
        end else if (a < ANGLE_HALF) begin
            eawc_wave = 16'(pwm_cycle_reg >> 1) + prod[16:1];
        end else begin
            eawc_wave = 16'(pwm_cycle_reg >> 1) - prod[16:1];
        end
    endfunction

    // calculation sequencer: run for CALC_LEN-3 clocks then hand out U, V, W, CALC_LEN clocks in all
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            calc_state_reg <= CALC_IDLE;
            calc_cnt_reg <= 16'h0000;
            out_idx_reg <= 2'h0;
        end else if (!timer_ctrl_reg[BIT_CALC_EN] && !sw_start) begin
            calc_state_reg <= CALC_IDLE;
        end else if (calc_start) begin
            calc_state_reg <= CALC_RUN;
            calc_cnt_reg <= 16'h0000;
            out_idx_reg <= 2'h0;
        end else begin
            unique case (calc_state_reg)
                CALC_IDLE: ;
                CALC_RUN: begin
                    calc_cnt_reg <= calc_cnt_reg + 16'h0001;
                    if (calc_cnt_reg == 16'(CALC_LEN - 4)) begin
                        calc_state_reg <= CALC_OUT;
                    end
                end
                CALC_OUT: begin
                    out_idx_reg <= out_idx_reg == 2'h2 ? 2'h2 : out_idx_reg + 2'h1;
                    if (out_idx_reg == 2'h2) begin
                        calc_state_reg <= CALC_IDLE;
                    end
                end
            endcase
        end
    end

    // results latched at the start angle, delivered at the end
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            res_reg[0] <= 16'h0000;
            res_reg[1] <= 16'h0000;
            res_reg[2] <= 16'h0000;
        end else if (calc_state_reg == CALC_RUN && calc_cnt_reg == 16'h0000) begin
            res_reg[0] <= eawc_wave(angle_counter_reg, sine_table[angle_counter_reg]);
            res_reg[1] <= eawc_wave(ang_v, sine_table[ang_v]);
            res_reg[2] <= eawc_wave(ang_w, sine_table[ang_w]);
        end
    end

    // sequential delivery toward the pwm
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DUTY_DATA <= 16'h0000;
            DUTY_PHASE <= 2'h0;
            DUTY_VALID <= 1'b0;
        end else begin
            DUTY_VALID <= calc_state_reg == CALC_OUT && !calc_start;
            DUTY_PHASE <= out_idx_reg;
            DUTY_DATA <= res_reg[out_idx_reg];
        end
    end

    // compare registers: autoload or software, never both
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmp_reg[0] <= 16'h0000;
            cmp_reg[1] <= 16'h0000;
            cmp_reg[2] <= 16'h0000;
        end else if (timer_ctrl_reg[BIT_AUTOLOAD]) begin
            if (timer_ctrl_reg[BIT_CALC_EN] && calc_end && !calc_start) begin
                cmp_reg[0] <= res_reg[0];
                cmp_reg[1] <= res_reg[1];
                cmp_reg[2] <= res_reg[2];
            end
        end else if (wr_en && PADDR == OFS_CMP_U) begin
            cmp_reg[0] <= PWDATA[15:0];
        end else if (wr_en && PADDR == OFS_CMP_V) begin
            cmp_reg[1] <= PWDATA[15:0];
        end else if (wr_en && PADDR == OFS_CMP_W) begin
            cmp_reg[2] <= PWDATA[15:0];
        end
    end

    assign CMP_U = cmp_reg[0];
    assign CMP_V = cmp_reg[1];
    assign CMP_W = cmp_reg[2];

    // angle interrupt pulse from step or calc end
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ANGLE_IRQ <= 1'b0;
        end else begin
            ANGLE_IRQ <= calc_ctrl_reg[BIT_IRQ_SEL] ? (calc_end && !calc_start)
                : step_done;
        end
    end
endmodule

// ==== testbench/eawc_sva.sv ====
// Purpose: port checker for the angle timer and waveform calculator
// Assumes: zero-wait APB; control bits shadowed from bus writes
// Notes: bound into eawc_top below
`timescale 1ns/1ps
module eawc_sva
    import eawc_pkg::*;
#(
    parameter int CALC_LEN = 8
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic ANGLE_IRQ,
    input wire logic [1:0] DUTY_PHASE,
    input wire logic DUTY_VALID,
    input wire logic [15:0] CMP_U
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    logic wr, dirty_reg;
    logic [7:0] tctl_reg, cctl_reg;
    logic [15:0] per_reg;
    logic [11:0] gap_reg, since_reg, m_eff;
    logic [1:0] off_reg;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign m_eff = (per_reg[11:0] < PERIOD_MIN) ? PERIOD_MIN : per_reg[11:0];
    // shadow copies of control and period, taken at the write edge
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tctl_reg <= RST_CTRL;
            cctl_reg <= RST_CTRL;
            per_reg <= RST_PERIOD;
        end else if (wr) begin
            if (PADDR == OFS_TIMER_CTRL) tctl_reg <= PWDATA[7:0];
            if (PADDR == OFS_CALC_CTRL) cctl_reg <= PWDATA[7:0];
            if (PADDR == OFS_PERIOD) per_reg <= PWDATA[15:0];
        end
    end
    // cycles since the last interrupt, since the last start, and with timer idle
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gap_reg <= 12'h000;
            since_reg <= 12'h000;
            off_reg <= 2'h0;
            dirty_reg <= 1'b1;
        end else begin
            gap_reg <= ANGLE_IRQ ? 12'h001 : gap_reg + 12'h001;
            since_reg <= (wr && PADDR == OFS_CALC_CTRL && PWDATA[BIT_SW_START]) ? 12'h001
                : ((since_reg == 12'hFFF) ? since_reg : since_reg + 12'h001);
            off_reg <= (tctl_reg[BIT_TIMER_EN] || cctl_reg[BIT_IRQ_SEL]) ? 2'h0
                : ((off_reg == 2'h3) ? off_reg : off_reg + 2'h1);
            dirty_reg <= wr ? 1'b1 : (ANGLE_IRQ ? 1'b0 : dirty_reg);
        end
    end
    sequence s_u_beat;
        DUTY_VALID && DUTY_PHASE == 2'h0;
    endsequence
    sequence s_vw_beats;
        DUTY_VALID && DUTY_PHASE == 2'h1 ##1 DUTY_VALID && DUTY_PHASE == 2'h2;
    endsequence
    AST_APB_READY: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access phase");
    AST_BAD_ADDR: assert property (PSEL && !PENABLE && !PWRITE && PADDR > OFS_STATUS
        |=> PSLVERR && PRDATA == 32'h0) else $error("unmapped read not refused");
    AST_BEATS: assert property (s_u_beat |=> s_vw_beats)
        else $error("phase beats out of order");
    AST_CALC_TIME: assert property (s_u_beat and !cctl_reg[BIT_SYNC_EN]
        |-> since_reg == 12'(CALC_LEN - 1)) else $error("calculation time wrong");
    AST_IRQ_CALC: assert property (cctl_reg[BIT_IRQ_SEL] && DUTY_VALID && DUTY_PHASE == 2'h2
        |-> ANGLE_IRQ) else $error("no interrupt after calculation");
    AST_STEP_GAP: assert property (ANGLE_IRQ && !dirty_reg && !cctl_reg[BIT_IRQ_SEL]
        && tctl_reg[5:4] == 2'h0 |-> gap_reg == m_eff
        || (per_reg[15:12] != 4'h0 && gap_reg == m_eff + 12'h001))
        else $error("step period wrong");
    AST_TIMER_OFF: assert property (off_reg >= 2'h2 |-> !ANGLE_IRQ)
        else $error("step while timer disabled");
    AST_CMP_LOCK: assert property (wr && PADDR == OFS_CMP_U && tctl_reg[BIT_AUTOLOAD]
        && !cctl_reg[BIT_SYNC_EN] && since_reg > 12'(CALC_LEN + 4) |=> $stable(CMP_U))
        else $error("compare written during autoload");
endmodule
bind eawc_top eawc_sva #(.CALC_LEN(CALC_LEN)) u_sva (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ANGLE_IRQ(ANGLE_IRQ),
    .DUTY_PHASE(DUTY_PHASE), .DUTY_VALID(DUTY_VALID), .CMP_U(CMP_U));

// ==== testbench/eawc_pwm_model.sv ====
// Purpose: far-side model of the PWM generator and position sensor
// Assumes: duty beats arrive as U, V, W on consecutive cycles
// Notes: the bench asks for a position edge through pos_req
`timescale 1ns/1ps
module eawc_pwm_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] duty_data,
    input wire logic [1:0] duty_phase,
    input wire logic duty_valid,
    input wire logic pos_req,
    output logic pos_detect,
    output logic [15:0] duty_u,
    output logic [15:0] duty_w,
    output int beats
);
    // sensor answers one clock after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_detect <= 1'b0;
        end else begin
            pos_detect <= pos_req;
        end
    end
    // keep the U and W duties by phase and count the beats
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_u <= 16'h0000;
            duty_w <= 16'h0000;
            beats <= 0;
        end else if (duty_valid) begin
            beats <= beats + 1;
            if (duty_phase == 2'h0) duty_u <= duty_data;
            if (duty_phase == 2'h2) duty_w <= duty_data;
        end
    end
endmodule

// ==== testbench/eawc_top_bench.sv ====
// Purpose: register-level test of the angle timer and waveform calculator
// Assumes: calculation length shortened to 8 clocks
// Notes: sine table filled with a simple ramp pattern
`timescale 1ns/1ps
module eawc_top_bench import eawc_pkg::*;;
    localparam int CL = 8;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pos_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic prdy, perr, irq, dvalid, pos;
    logic [15:0] ddata, cmp_u, cmp_v, cmp_w, pm_u, pm_w;
    logic [1:0] dphase;
    int beats, n, b;
    int n_fail = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    eawc_top #(.CALC_LEN(CL)) uut (.SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(prdy), .PSLVERR(perr), .POS_DETECT(pos), .ANGLE_IRQ(irq), .DUTY_DATA(ddata),
        .DUTY_PHASE(dphase), .DUTY_VALID(dvalid), .CMP_U(cmp_u), .CMP_V(cmp_v), .CMP_W(cmp_w));
    eawc_pwm_model pm (.clk(clk), .rst_n(rst_n), .duty_data(ddata), .duty_phase(dphase),
        .duty_valid(dvalid), .pos_req(pos_req), .pos_detect(pos), .duty_u(pm_u),
        .duty_w(pm_w), .beats(beats));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    // one APB transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (prdy !== 1'b1 && i < 50);
        tmo(i, 50);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wait_idle();
        logic [31:0] q;
        int i;
        i = 0;
        do begin
            apb(1'b0, OFS_CALC_CTRL, 32'h0, q);
            i++;
        end while (q[BIT_BUSY] !== 1'b0 && i < 40);
        tmo(i, 40);
    endtask
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (irq !== 1'b1 && c < 400);
        tmo(c, 400);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] tv(input int i);
        return 8'(i * 7 + 3);
    endfunction
    // expected duty at one angle; amplitude 4, half cycle 768
    function automatic logic [15:0] calc(input int a, input logic three);
        int p;
        p = tv(a) * 4;
        if (three) begin
            p = (a < 192) ? 768 + p / 2 : 768 - p / 2;
        end
        return 16'(p);
    endfunction
    task automatic calc_case(input logic [7:0] ctl, input int a);
        int v, w;
        v = (a + (ctl[BIT_PHASE_ORDER] ? 256 : 128)) % 384;
        w = (a + (ctl[BIT_PHASE_ORDER] ? 128 : 256)) % 384;
        wr(OFS_TIMER_CTRL, {24'h0, ctl});
        wr(OFS_ANGLE, 32'(a));
        wr(OFS_CALC_CTRL, 32'h8);
        wait_idle();
        rdc(OFS_CMP_U, {16'h0, calc(a, ctl[BIT_MOD_SEL])});
        rdc(OFS_CMP_V, {16'h0, calc(v, ctl[BIT_MOD_SEL])});
        rdc(OFS_CMP_W, {16'h0, calc(w, ctl[BIT_MOD_SEL])});
        chk({16'h0, pm_w}, {16'h0, calc(w, ctl[BIT_MOD_SEL])});
    endtask
    task automatic step_case(input logic [7:0] ctl, input logic [8:0] a0, input logic [8:0] e);
        wr(OFS_TIMER_CTRL, {24'h0, ctl & 8'hFE});
        wr(OFS_ANGLE, {23'h0, a0});
        wr(OFS_TIMER_CTRL, {24'h0, ctl});
        wait_irq(n);
        rdc(OFS_ANGLE, {23'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFS_TIMER_CTRL, 32'h0);
        rdc(OFS_PERIOD, 32'h10);
        rdc(8'h40, 32'h0);
        for (int i = 0; i < 384; i++) begin
            wr(OFS_ANGLE, 32'(i));
            wr(OFS_TABLE_DATA, {24'h0, tv(i)});
        end
        wr(OFS_AMPLITUDE, 32'h4);
        wr(OFS_PWM_CYCLE, 32'h600);
        calc_case(8'h02, 5);
        calc_case(8'h0A, 200);
        calc_case(8'h4A, 200);
        calc_case(8'h42, 300);
        wr(OFS_CALC_CTRL, 32'h8);
        rdc(OFS_CALC_CTRL, 32'h4);
        wr(OFS_CALC_CTRL, 32'h8);
        wait_idle();
        // autoload on, then software owns the compares
        calc_case(8'h06, 5);
        chk({16'h0, cmp_u}, {16'h0, calc(5, 1'b0)});
        chk({16'h0, cmp_w}, {16'h0, calc(261, 1'b0)});
        wr(OFS_CMP_U, 32'h123);
        @(posedge clk);
        chk({16'h0, cmp_u}, {16'h0, calc(5, 1'b0)});
        wr(OFS_TIMER_CTRL, 32'h0);
        wr(OFS_CMP_U, 32'h123);
        rdc(OFS_CMP_U, 32'h123);
        wr(OFS_TIMER_CTRL, 32'h2);
        rdc(OFS_CMP_U, {16'h0, calc(5, 1'b0)});
        chk({16'h0, cmp_u}, 32'h123);
        wr(OFS_CALC_CTRL, 32'h9);
        wait_irq(n);
        chk(32'(n < CL + 8), 32'h1);
        wr(OFS_CALC_CTRL, 32'h0);
        // timer stepping, wrap both ways, floor on the period
        wr(OFS_PERIOD, 32'h5);
        step_case(8'h01, 9'h17F, 9'h000);
        wait_irq(n);
        wait_irq(n);
        chk(n, 16);
        wr(OFS_ANGLE, 32'h64);
        rdc(OFS_ANGLE, 32'h64);
        wr(OFS_TIMER_CTRL, 32'h0);
        wr(OFS_TIMER_CTRL, 32'h1);
        wait_irq(n);
        chk(32'(n >= 16 && n <= 18), 32'h1);
        step_case(8'h81, 9'h000, 9'h17F);
        wr(OFS_TIMER_CTRL, 32'h0);
        wr(OFS_ANGLE, 32'h4D);
        pos_req <= 1'b1;
        @(posedge clk);
        pos_req <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(OFS_CAPTURE, 32'h4D);
        // trimmed period over a group, then divider changed while running
        wr(OFS_PERIOD, 32'h8010);
        wr(OFS_TIMER_CTRL, 32'h1);
        wait_irq(n);
        b = 0;
        for (int i = 0; i < 16; i++) begin
            wait_irq(n);
            b += n;
        end
        chk(b, 264);
        wr(OFS_PERIOD, 32'h10);
        wr(OFS_TIMER_CTRL, 32'h11);
        wait_irq(n);
        wait_irq(n);
        chk(n, 32);
        // angle write starts a calculation in sync mode
        wr(OFS_TIMER_CTRL, 32'h2);
        wr(OFS_CALC_CTRL, 32'h2);
        b = beats;
        wr(OFS_ANGLE, 32'hA);
        wait_idle();
        chk(beats - b, 3);
        chk({16'h0, pm_u}, {16'h0, calc(10, 1'b0)});
        report_and_stop();
    end
endmodule
